//--- hw/tsense_status.sv
`timescale 1ns/1ns
// Summary of operation
// - high bias select forces high bias current, overriding medium/low select.
// - status1 bit 7 shows converter busy, live.
// - status1 bit 6 set on local over-temperature alarm.
// - status1 bit 5 set on local under-temperature alarm.
// - status1 bit 4 set on any remote diode open fault.
// - status1 bit 3 set when any remote channel raises over or under alarm.
// - status1 bits 6..3 stay set until reset or status read.
// - status2 bits 7/6: channel 1 under/over flags.
// - status2 bits 5/4: channel 2 under/over flags.
// - status2 bits 3/2: channel 3 under/over flags.
// - status2 bits 1/0: channel 4 under/over flags.
// - status2 flags stay set until reset or status read.
// - two-channel variant leaves channel 3 and 4 bits unimplemented.
// - two three-level straps select one of nine 7-bit slave addresses.
// - floating strap is a third level distinct from low and high.
// - status read clears flags unless the condition still persists.
// - status read never touches the separate alert latch.
// - straps sampled once after reset; address held latched afterwards.
module tsense_status #(
  parameter int unsigned NUM_REMOTE = 4
) (
  // clock and reset
  input  wire logic                     I_CLK,
  input  wire logic                     I_RSTN,
  // converter and comparator events, same clock
  input  wire tsense_pkg::alarm_events_t I_EVENTS,
  // reads from the bus engine, one-cycle pulses
  input  wire logic                     I_STATUS1_READ,
  input  wire logic                     I_STATUS2_READ,
  // bias configuration bits
  input  wire logic                     I_HIGH_BIAS_SELECT,
  input  wire logic                     I_MEDIUM_LOW_BIAS_SELECT,
  // address strap comparators, asynchronous
  input  wire tsense_pkg::strap_sense_t  I_STRAP,
  // status bytes
  output logic [7:0]                    O_STATUS1,
  output logic [7:0]                    O_STATUS2,
  // diode bias drive
  output tsense_pkg::bias_t             O_BIAS,
  // slave address
  output logic [6:0]                    O_SLAVE_ADDR,
  output logic                          O_ADDR_VALID
);

  logic       local_over_flag;
  logic       local_under_flag;
  logic       open_flag;
  logic       remote_sum_flag;
  logic [3:0] ch_over_flag;
  logic [3:0] ch_under_flag;
  logic [3:0] chan_mask;
  logic       any_open;
  logic       any_remote;
  logic       status_read;

  // set beats clear, so a condition still live in the read cycle keeps its flag
  function automatic logic sticky_next(input logic cond, input logic flag, input logic clr);
    return cond | (flag & ~clr);
  endfunction

  // ----------------------------------------------------------------
  // channel population
  // ----------------------------------------------------------------
  // absent channels are masked so stray comparator levels cannot raise the summary
  generate
    for (genvar c = 0; c < tsense_pkg::MAX_REMOTE; c++) begin : g_mask
      assign chan_mask[c] = (c < NUM_REMOTE) ? 1'b1 : 1'b0;
    end
  endgenerate

  always_comb begin
    any_open    = |(I_EVENTS.open_fault & chan_mask);
    any_remote  = |((I_EVENTS.remote_over | I_EVENTS.remote_under) & chan_mask);
    // either byte address reads out as the status register
    status_read = I_STATUS1_READ | I_STATUS2_READ;
  end

  // ----------------------------------------------------------------
  // bias selection
  // ----------------------------------------------------------------
  always_ff @(posedge I_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      O_BIAS <= tsense_pkg::BIAS_MEDIUM;
    end else if (I_HIGH_BIAS_SELECT) begin
      O_BIAS <= tsense_pkg::BIAS_HIGH;
    end else if (I_MEDIUM_LOW_BIAS_SELECT) begin
      O_BIAS <= tsense_pkg::BIAS_LOW;
    end else begin
      O_BIAS <= tsense_pkg::BIAS_MEDIUM;
    end
  end

  // ----------------------------------------------------------------
  // sticky flags of the first byte
  // ----------------------------------------------------------------
  // a live condition re-sets in the read cycle, so set beats clear;
  // the alert latch lives elsewhere and sees nothing of the read
  always_ff @(posedge I_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      local_over_flag  <= 1'b0;
      local_under_flag <= 1'b0;
      open_flag        <= 1'b0;
      remote_sum_flag  <= 1'b0;
    end else begin
      local_over_flag  <= sticky_next(I_EVENTS.local_over, local_over_flag, status_read);
      local_under_flag <= sticky_next(I_EVENTS.local_under, local_under_flag, status_read);
      open_flag        <= sticky_next(any_open, open_flag, status_read);
      remote_sum_flag  <= sticky_next(any_remote, remote_sum_flag, status_read);
    end
  end

  // ----------------------------------------------------------------
  // per-channel flags of the second byte
  // ----------------------------------------------------------------
  generate
    for (genvar c = 0; c < tsense_pkg::MAX_REMOTE; c++) begin : g_chan
      if (c < NUM_REMOTE) begin : g_on
        always_ff @(posedge I_CLK or negedge I_RSTN) begin
          if (!I_RSTN) begin
            ch_over_flag[c]  <= 1'b0;
            ch_under_flag[c] <= 1'b0;
          end else begin
            ch_over_flag[c]  <= sticky_next(I_EVENTS.remote_over[c], ch_over_flag[c], status_read);
            ch_under_flag[c] <= sticky_next(I_EVENTS.remote_under[c], ch_under_flag[c], status_read);
          end
        end
      end else begin : g_off
        assign ch_over_flag[c]  = 1'b0;
        assign ch_under_flag[c] = 1'b0;
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // status outputs
  // ----------------------------------------------------------------
  // the read path sees the flag as of the read cycle; clearing shows one cycle later
  always_ff @(posedge I_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      O_STATUS1 <= tsense_pkg::STAT1_RESET;
    end else begin
      O_STATUS1[tsense_pkg::STAT1_BUSY_BIT]   <= I_EVENTS.busy;
      O_STATUS1[tsense_pkg::STAT1_LOVER_BIT]  <=
        sticky_next(I_EVENTS.local_over, local_over_flag, status_read);
      O_STATUS1[tsense_pkg::STAT1_LUNDER_BIT] <=
        sticky_next(I_EVENTS.local_under, local_under_flag, status_read);
      O_STATUS1[tsense_pkg::STAT1_OPEN_BIT]   <=
        sticky_next(any_open, open_flag, status_read);
      O_STATUS1[tsense_pkg::STAT1_RSUM_BIT]   <=
        sticky_next(any_remote, remote_sum_flag, status_read);
      O_STATUS1[2:0]                          <= tsense_pkg::STAT1_UNUSED_VAL;
    end
  end

  generate
    for (genvar c = 0; c < tsense_pkg::MAX_REMOTE; c++) begin : g_out
      always_ff @(posedge I_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
          O_STATUS2[tsense_pkg::STAT2_UNDER_TOP - 2 * c] <= 1'b0;
          O_STATUS2[tsense_pkg::STAT2_OVER_TOP - 2 * c]  <= 1'b0;
        end else if (c < NUM_REMOTE) begin
          O_STATUS2[tsense_pkg::STAT2_UNDER_TOP - 2 * c] <=
            sticky_next(I_EVENTS.remote_under[c], ch_under_flag[c], status_read);
          O_STATUS2[tsense_pkg::STAT2_OVER_TOP - 2 * c] <=
            sticky_next(I_EVENTS.remote_over[c], ch_over_flag[c], status_read);
        end else begin
          O_STATUS2[tsense_pkg::STAT2_UNDER_TOP - 2 * c] <= 1'b0;
          O_STATUS2[tsense_pkg::STAT2_OVER_TOP - 2 * c]  <= 1'b0;
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // slave address from straps
  // ----------------------------------------------------------------
  tsense_strap_decode u_strap (
    .i_clk   (I_CLK),
    .i_rstn  (I_RSTN),
    .i_strap (I_STRAP),
    .o_addr  (O_SLAVE_ADDR),
    .o_valid (O_ADDR_VALID)
  );

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  property p_bias_high;
    @(posedge I_CLK) disable iff (!I_RSTN)
    I_HIGH_BIAS_SELECT |=> (O_BIAS == tsense_pkg::BIAS_HIGH);
  endproperty
  a_bias_high: assert property (p_bias_high) else $error("high bias not applied");

  property p_bias_low;
    @(posedge I_CLK) disable iff (!I_RSTN)
    (!I_HIGH_BIAS_SELECT && I_MEDIUM_LOW_BIAS_SELECT) |=> (O_BIAS == tsense_pkg::BIAS_LOW);
  endproperty
  a_bias_low: assert property (p_bias_low) else $error("low bias not applied");

  property p_busy;
    @(posedge I_CLK) disable iff (!I_RSTN)
    ##1 (O_STATUS1[7] == $past(I_EVENTS.busy));
  endproperty
  a_busy: assert property (p_busy) else $error("busy bit does not follow converter");

  property p_local_over;
    @(posedge I_CLK) disable iff (!I_RSTN)
    I_EVENTS.local_over |=> O_STATUS1[6];
  endproperty
  a_local_over: assert property (p_local_over) else $error("local over flag missed");

  property p_local_under;
    @(posedge I_CLK) disable iff (!I_RSTN)
    (I_EVENTS.local_under && status_read) |=> (O_STATUS1[5] && local_under_flag);
  endproperty
  a_local_under: assert property (p_local_under) else $error("local under flag lost on read");

  property p_open;
    @(posedge I_CLK) disable iff (!I_RSTN)
    (|I_EVENTS.open_fault[1:0]) |=> O_STATUS1[4];
  endproperty
  a_open: assert property (p_open) else $error("open fault flag missed");

  property p_summary;
    @(posedge I_CLK) disable iff (!I_RSTN)
    (I_EVENTS.remote_over[0] || I_EVENTS.remote_under[1]) |=> (O_STATUS1[3] && (O_STATUS2[6] || O_STATUS2[5]));
  endproperty
  a_summary: assert property (p_summary) else $error("remote summary flag missed");

  property p_sticky1;
    @(posedge I_CLK) disable iff (!I_RSTN)
    (O_STATUS1[6] && !status_read) |=> O_STATUS1[6];
  endproperty
  a_sticky1: assert property (p_sticky1) else $error("local over flag dropped without read");

  property p_ch1;
    @(posedge I_CLK) disable iff (!I_RSTN)
    I_EVENTS.remote_under[0] |=> (O_STATUS2[7] ##1 (O_STATUS2[7] || $past(status_read)));
  endproperty
  a_ch1: assert property (p_ch1) else $error("channel 1 under flag wrong");

  property p_clear;
    @(posedge I_CLK) disable iff (!I_RSTN)
    (status_read && !I_EVENTS.remote_over[1]) |=> !O_STATUS2[4];
  endproperty
  a_clear: assert property (p_clear) else $error("channel 2 over flag survived read");

  property p_unused;
    @(posedge I_CLK) disable iff (!I_RSTN)
    O_STATUS1[2:0] == 3'h0;
  endproperty
  a_unused: assert property (p_unused) else $error("unused status bits not zero");

  property p_addr_hold;
    @(posedge I_CLK) disable iff (!I_RSTN)
    (O_ADDR_VALID && $past(O_ADDR_VALID)) |-> $stable(O_SLAVE_ADDR);
  endproperty
  a_addr_hold: assert property (p_addr_hold) else $error("slave address changed after latch");

  property p_addr_ready;
    @(posedge I_CLK) disable iff (!I_RSTN)
    $rose(I_RSTN) |-> ##[1:16] O_ADDR_VALID;
  endproperty
  a_addr_ready: assert property (p_addr_ready) else $error("address never latched");

  property p_bias_med;
    @(posedge I_CLK) disable iff (!I_RSTN)
    (!I_HIGH_BIAS_SELECT && !I_MEDIUM_LOW_BIAS_SELECT) |=> (O_BIAS == tsense_pkg::BIAS_MEDIUM);
  endproperty
  a_bias_med: assert property (p_bias_med) else $error("medium bias not applied");

  property p_local_under_set;
    @(posedge I_CLK) disable iff (!I_RSTN)
    I_EVENTS.local_under |=> O_STATUS1[5];
  endproperty
  a_local_under_set: assert property (p_local_under_set) else $error("local under flag missed");

  property p_sticky_open;
    @(posedge I_CLK) disable iff (!I_RSTN)
    (O_STATUS1[4] && !status_read) |=> O_STATUS1[4];
  endproperty
  a_sticky_open: assert property (p_sticky_open) else $error("open flag dropped without read");

  property p_sticky_sum;
    @(posedge I_CLK) disable iff (!I_RSTN)
    (O_STATUS1[3] && !status_read) |=> O_STATUS1[3];
  endproperty
  a_sticky_sum: assert property (p_sticky_sum) else $error("summary flag dropped without read");

  property p_clear1;
    @(posedge I_CLK) disable iff (!I_RSTN)
    (status_read && !I_EVENTS.local_over) |=> !O_STATUS1[6];
  endproperty
  a_clear1: assert property (p_clear1) else $error("local over flag survived read");

  property p_sum_clear;
    @(posedge I_CLK) disable iff (!I_RSTN)
    (status_read && !any_remote) |=> !O_STATUS1[3];
  endproperty
  a_sum_clear: assert property (p_sum_clear) else $error("summary flag survived read");

  property p_ch2;
    @(posedge I_CLK) disable iff (!I_RSTN)
    I_EVENTS.remote_under[1] |=> O_STATUS2[5];
  endproperty
  a_ch2: assert property (p_ch2) else $error("channel 2 under flag missed");

  property p_ch3;
    @(posedge I_CLK) disable iff (!I_RSTN)
    (NUM_REMOTE > 2 && I_EVENTS.remote_over[2]) |=> O_STATUS2[2];
  endproperty
  a_ch3: assert property (p_ch3) else $error("channel 3 over flag missed");

  property p_ch4;
    @(posedge I_CLK) disable iff (!I_RSTN)
    (NUM_REMOTE > 3 && I_EVENTS.remote_under[3]) |=> O_STATUS2[1];
  endproperty
  a_ch4: assert property (p_ch4) else $error("channel 4 under flag missed");

  property p_sticky2;
    @(posedge I_CLK) disable iff (!I_RSTN)
    (O_STATUS2[6] && !status_read) |=> O_STATUS2[6];
  endproperty
  a_sticky2: assert property (p_sticky2) else $error("channel 1 over flag dropped without read");

  property p_small;
    @(posedge I_CLK) disable iff (!I_RSTN)
    (NUM_REMOTE <= 2) |-> (O_STATUS2[3:0] == 4'h0);
  endproperty
  a_small: assert property (p_small) else $error("absent channel bits not zero");

  property p_addr_keep;
    @(posedge I_CLK) disable iff (!I_RSTN)
    O_ADDR_VALID |=> O_ADDR_VALID;
  endproperty
  a_addr_keep: assert property (p_addr_keep) else $error("address valid dropped");

endmodule

//--- hw/tsense_strap_decode.sv
`timescale 1ns/1ns
module tsense_strap_decode (
  // clock and reset
  input  wire logic                    i_clk,
  input  wire logic                    i_rstn,
  // strap comparators, asynchronous
  input  wire tsense_pkg::strap_sense_t i_strap,
  // latched address
  output logic [6:0]                   o_addr,
  output logic                         o_valid
);

  tsense_pkg::strap_sense_t sync1;
  tsense_pkg::strap_sense_t sync2;
  tsense_pkg::strap_state_t state;
  logic [3:0]               settle_cnt;
  tsense_pkg::strap_level_t lvl_a;
  tsense_pkg::strap_level_t lvl_b;

  function automatic tsense_pkg::strap_level_t sense_level(input logic above, input logic below);
    tsense_pkg::strap_level_t lvl;
    lvl = tsense_pkg::LVL_FLOAT;
    if (above) begin
      lvl = tsense_pkg::LVL_HIGH;
    end else if (below) begin
      lvl = tsense_pkg::LVL_LOW;
    end
    return lvl;
  endfunction

  // ----------------------------------------------------------------
  // synchroniser
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      sync1 <= '0;
      sync2 <= '0;
    end else begin
      sync1 <= i_strap;
      sync2 <= sync1;
    end
  end

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  always_comb begin
    lvl_a = sense_level(sync2.a_above, sync2.a_below);
    lvl_b = sense_level(sync2.b_above, sync2.b_below);
  end

  // ----------------------------------------------------------------
  // one-shot capture after release of reset
  // ----------------------------------------------------------------
  // straps are only read once so the comparator bias can be dropped later
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      state      <= tsense_pkg::STRAP_SETTLE;
      settle_cnt <= 4'h0;
      o_addr     <= tsense_pkg::ADDR_RESET;
      o_valid    <= 1'b0;
    end else begin
      case (state)
        tsense_pkg::STRAP_SETTLE: begin
          if (settle_cnt == tsense_pkg::SETTLE_LAST) begin
            state   <= tsense_pkg::STRAP_LATCHED;
            o_valid <= 1'b1;
            case (lvl_a)
              tsense_pkg::LVL_LOW:   o_addr <= tsense_pkg::ADDR_BASE_A_LOW + 7'(lvl_b);
              tsense_pkg::LVL_FLOAT: o_addr <= tsense_pkg::ADDR_BASE_A_FLOAT + 7'(lvl_b);
              default:               o_addr <= tsense_pkg::ADDR_BASE_A_HIGH + 7'(lvl_b);
            endcase
          end else begin
            settle_cnt <= settle_cnt + 4'h1;
          end
        end
        tsense_pkg::STRAP_LATCHED: begin
          state <= tsense_pkg::STRAP_LATCHED;
        end
        default: begin
          state <= tsense_pkg::STRAP_SETTLE;
        end
      endcase
    end
  end

endmodule

//--- include/tsense_pkg.sv
package tsense_pkg;

  // ----------------------------------------------------------------
  // status byte layout
  // ----------------------------------------------------------------
  localparam int unsigned STAT1_BUSY_BIT   = 7;
  localparam int unsigned STAT1_LOVER_BIT  = 6;
  localparam int unsigned STAT1_LUNDER_BIT = 5;
  localparam int unsigned STAT1_OPEN_BIT   = 4;
  localparam int unsigned STAT1_RSUM_BIT   = 3;
  localparam logic [2:0]  STAT1_UNUSED_VAL = 3'h0;
  // channel n (0-based): under flag at 7-2n, over flag at 6-2n
  localparam int unsigned STAT2_UNDER_TOP  = 7;
  localparam int unsigned STAT2_OVER_TOP   = 6;
  localparam int unsigned MAX_REMOTE       = 4;
  localparam int unsigned SMALL_REMOTE     = 2;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] STAT1_RESET = 8'h00;
  localparam logic [7:0] STAT2_RESET = 8'h00;
  localparam logic [6:0] ADDR_RESET  = 7'h00;

  // ----------------------------------------------------------------
  // slave address table, base per strap a level, offset by strap b
  // ----------------------------------------------------------------
  localparam logic [6:0] ADDR_BASE_A_LOW   = 7'h18;
  localparam logic [6:0] ADDR_BASE_A_FLOAT = 7'h29;
  localparam logic [6:0] ADDR_BASE_A_HIGH  = 7'h4C;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS    = 10;
  localparam int unsigned STRAP_SETTLE_NS  = 100;
  localparam int unsigned STRAP_SETTLE_CYC = (STRAP_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0]  SETTLE_LAST      = 4'(STRAP_SETTLE_CYC - 1);

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    BIAS_MEDIUM = 2'b00,
    BIAS_LOW    = 2'b01,
    BIAS_HIGH   = 2'b10
  } bias_t;

  typedef enum logic [1:0] {
    LVL_LOW   = 2'b00,
    LVL_FLOAT = 2'b01,
    LVL_HIGH  = 2'b10
  } strap_level_t;

  typedef enum logic [1:0] {
    STRAP_SETTLE  = 2'b00,
    STRAP_LATCHED = 2'b01
  } strap_state_t;

  typedef struct packed {
    logic       busy;
    logic       local_over;
    logic       local_under;
    logic [3:0] open_fault;
    logic [3:0] remote_over;
    logic [3:0] remote_under;
  } alarm_events_t;

  // each strap pin seen by two comparators; neither tripped means floating
  typedef struct packed {
    logic a_above;
    logic a_below;
    logic b_above;
    logic b_below;
  } strap_sense_t;

endpackage

//--- tb/tsense_host_model.sv
`timescale 1ns/1ns
// ----------------------------------------------------------------
// bus host side: turns byte reads into one-cycle read pulses
// ----------------------------------------------------------------
module tsense_host_model (
  // clock
  input  wire logic       i_clk,
  // status bytes seen by the bus engine
  input  wire logic [7:0] i_status1,
  input  wire logic [7:0] i_status2,
  // read strobes
  output logic            o_read1,
  output logic            o_read2,
  // captured byte, one-cycle strobe
  output logic            o_valid,
  output logic [7:0]      o_data
);
  initial begin
    o_read1 = 1'b0;
    o_read2 = 1'b0;
    o_valid = 1'b0;
    o_data  = 8'h00;
  end

  // data is taken in the read cycle itself, before the clear lands
  task automatic read_byte(input logic sel);
    logic [7:0] d;
    logic       again;
    again = 1'b1;
    while (again) begin
      @(posedge i_clk);
      #1;
      d       = sel ? i_status2 : i_status1;
      o_read1 = !sel;
      o_read2 = sel;
      @(posedge i_clk);
      #1;
      o_read1 = 1'b0;
      o_read2 = 1'b0;
      // all ones in the low seven bits of status1 means a collision: read again
      again = !sel && (d[6:0] === 7'h7F);
    end
    o_data  = d;
    o_valid = 1'b1;
    @(posedge i_clk);
    #1;
    o_valid = 1'b0;
  endtask
endmodule

//--- tb/tsense_status_tb.sv
`timescale 1ns/1ns
`define CHECK(act, exp) begin num_checks++; if ((act) !== (exp)) begin mismatches++; \
  $display("mismatch at %0t: got %h expected %h", $time, act, exp); end end
module tsense_status_tb;
  logic                       clk, rstn, hb, mlb, probe_stb;
  tsense_pkg::alarm_events_t  ev, pat;
  tsense_pkg::strap_sense_t   strap;
  tsense_pkg::bias_t          bias;
  logic                       rd1, rd2, hvld, avld;
  logic [7:0]                 hdat, s1, s2, s2b, probe_val, e;
  logic [6:0]                 addr;
  logic [7:0]                 exp_q[$];
  logic [6:0]                 addr_tab [9] = '{7'h18, 7'h19, 7'h1A, 7'h29, 7'h2A, 7'h2B, 7'h4C, 7'h4D, 7'h4E};
  int                         mismatches, num_checks, cycles, seed, i, k, a, b;

  tsense_status #(.NUM_REMOTE(4)) uut (
    .I_CLK(clk), .I_RSTN(rstn), .I_EVENTS(ev), .I_STATUS1_READ(rd1), .I_STATUS2_READ(rd2),
    .I_HIGH_BIAS_SELECT(hb), .I_MEDIUM_LOW_BIAS_SELECT(mlb), .I_STRAP(strap),
    .O_STATUS1(s1), .O_STATUS2(s2), .O_BIAS(bias), .O_SLAVE_ADDR(addr), .O_ADDR_VALID(avld));
  tsense_status #(.NUM_REMOTE(2)) uut_small (
    .I_CLK(clk), .I_RSTN(rstn), .I_EVENTS(ev), .I_STATUS1_READ(rd1), .I_STATUS2_READ(rd2),
    .I_HIGH_BIAS_SELECT(hb), .I_MEDIUM_LOW_BIAS_SELECT(mlb), .I_STRAP(strap),
    .O_STATUS1(), .O_STATUS2(s2b), .O_BIAS(), .O_SLAVE_ADDR(), .O_ADDR_VALID());
  tsense_host_model host (
    .i_clk(clk), .i_status1(s1), .i_status2(s2), .o_read1(rd1), .o_read2(rd2), .o_valid(hvld), .o_data(hdat));

  always #5 clk = ~clk;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [1:0] lvl(input int l);
    return (l == 0) ? 2'b01 : (l == 1) ? 2'b00 : 2'b10;
  endfunction

  function automatic logic [7:0] exp1(input tsense_pkg::alarm_events_t v);
    return {v.busy, v.local_over, v.local_under, |v.open_fault, |(v.remote_over | v.remote_under), 3'h0};
  endfunction

  function automatic logic [7:0] exp2(input tsense_pkg::alarm_events_t v);
    logic [7:0] r;
    for (int n = 0; n < 4; n++) begin
      r[7 - 2 * n] = v.remote_under[n];
      r[6 - 2 * n] = v.remote_over[n];
    end
    return r;
  endfunction

  task automatic rd(input logic sel, input logic [7:0] x);
    exp_q.push_back(x);
    host.read_byte(sel);
  endtask

  task automatic probe(input logic [7:0] x, input logic [7:0] act);
    exp_q.push_back(x);
    probe_val = act;
    probe_stb = 1'b1;
    @(posedge clk);
    #1;
    probe_stb = 1'b0;
  endtask

  task automatic do_reset();
    rstn = 1'b0;
    repeat (12) @(posedge clk);
    #1;
    rstn = 1'b1;
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // monitor: oldest note against each result as it appears
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    if (hvld === 1'b1 || probe_stb === 1'b1) begin
      e = (exp_q.size() > 0) ? exp_q.pop_front() : 8'hXX;
      `CHECK((hvld === 1'b1) ? hdat : probe_val, e)
    end
  end

  // hang guard sized well above the expected run of under a thousand cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles >= 20000) begin
      mismatches++;
      print_verdict();
    end
  end

  initial begin
    clk = 1'b0; rstn = 1'b0; hb = 1'b0; mlb = 1'b0; probe_stb = 1'b0; probe_val = 8'h00;
    ev = '0; strap = '0; seed = 32'h486d8412; mismatches = 0; num_checks = 0; cycles = 0;
    // address straps: every level pair, one reset each, then changes ignored
    for (a = 0; a < 3; a++) begin
      for (b = 0; b < 3; b++) begin
        strap = {lvl(a), lvl(b)};
        do_reset();
        for (k = 0; k < 40 && avld !== 1'b1; k++) @(posedge clk);
        #1;
        probe({1'b0, addr_tab[3 * a + b]}, {1'b0, addr});
        strap = 4'($random(seed));
        repeat (20) @(posedge clk);
        #1;
        probe({1'b1, addr_tab[3 * a + b]}, {avld, addr});
      end
    end
    $display("test address done");
    // bias: every select pair, high select wins
    for (i = 0; i < 4; i++) begin
      {hb, mlb} = 2'(i);
      repeat (2) @(posedge clk);
      #1;
      probe({6'h00, hb ? tsense_pkg::BIAS_HIGH : mlb ? tsense_pkg::BIAS_LOW : tsense_pkg::BIAS_MEDIUM},
            {6'h00, bias});
    end
    $display("test bias done");
    // busy is live, not sticky, and a read does not clear it
    ev.busy = 1'b1;
    repeat (2) @(posedge clk);
    #1;
    rd(1'b0, 8'h80);
    rd(1'b0, 8'h80);
    ev.busy = 1'b0;
    rd(1'b0, 8'h00);
    $display("test busy done");
    // one-cycle random alarms: sticky until a read, then both bytes cleared
    for (i = 0; i < 24; i++) begin
      pat = 15'($random(seed));
      pat.busy = 1'b0;
      ev = pat;
      @(posedge clk);
      #1;
      probe(8'h00, {4'h0, s2b[3:0]});
      ev = '0;
      repeat (2) @(posedge clk);
      #1;
      if (i % 2 == 0) begin
        rd(1'b0, exp1(pat));
      end else begin
        rd(1'b1, exp2(pat));
      end
      rd(i % 2 == 0, 8'h00);
    end
    $display("test sticky flags done");
    // persisting condition survives reads, clears once gone
    ev.local_over = 1'b1;
    ev.local_under = 1'b1;
    repeat (2) @(posedge clk);
    #1;
    rd(1'b0, 8'h60);
    rd(1'b0, 8'h60);
    ev.local_over = 1'b0;
    ev.local_under = 1'b0;
    rd(1'b0, 8'h60);
    rd(1'b0, 8'h00);
    $display("test persist done");
    repeat (4) @(posedge clk);
    print_verdict();
  end

endmodule
